// File: src/acq_regs_pkg.sv
// Constants for the acquisition card register front end
package acq_regs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int RESULT_W = 12;
  localparam int CHAN_W = 3;
  localparam int GAIN_W = 3;
  localparam logic [3:0] OFF_COUNTER0 = 4'h0;
  localparam logic [3:0] OFF_COUNTER1 = 4'h1;
  localparam logic [3:0] OFF_COUNTER2 = 4'h2;
  localparam logic [3:0] OFF_COUNTER_CTRL = 4'h3;
  localparam logic [3:0] OFF_RESULT_LOW = 4'h4;
  localparam logic [3:0] OFF_RESULT_HIGH = 4'h5;
  localparam logic [3:0] OFF_DIGIN_LOW = 4'h6;
  localparam logic [3:0] OFF_DIGIN_HIGH = 4'h7;
  localparam logic [3:0] OFF_IRQ_CLEAR = 4'h8;
  localparam logic [3:0] OFF_GAIN_SELECT = 4'h9;
  localparam logic [3:0] OFF_CHANNEL_SELECT = 4'ha;
  localparam logic [3:0] OFF_MODE = 4'hb;
  localparam logic [3:0] OFF_SOFT_TRIGGER = 4'hc;
  localparam logic [3:0] OFF_DIGOUT_LOW = 4'hd;
  localparam logic [3:0] OFF_DIGOUT_HIGH = 4'he;
  localparam int READY_BIT = 4;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [2:0] GAIN_RESET = 3'h0;
  localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
  localparam logic [7:0] UNUSED_READ = 8'h00;
  typedef enum logic [1:0] {
    PORT_COUNTER0,
    PORT_COUNTER1,
    PORT_COUNTER2,
    PORT_COUNTER_CTRL
  } counter_port_t;
endpackage

// File: src/adc_card_register_interface.sv
// Card I/O register front end: decode, result readback, gain and channel
`timescale 1ns/100ps
// Function
// - Sixteen-location window, low four address bits
// - Read map: counters, result, digital inputs
// - Write map: counters, output bytes, controls
// - Result split: low eight, high four
// - High byte: bits 3-0, ready bit 4
// - Ready low when result available
// - Low byte read sets ready high, unless a conversion completes in the same cycle
// - Channel select write-only, three bits
// - Channel write switches multiplexer at the next clock edge (registered)
// - Gain select write-only, three bits
// - Gain codes 0-4 valid only; codes 5-7 are stored unchecked
// - Any trigger write starts conversion
module adc_card_register_interface #(
  parameter int DIGIN_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [acq_regs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [acq_regs_pkg::DATA_W-1:0] wdata_i,
  input wire logic rd_i,
  input wire logic wr_i,
  output logic [acq_regs_pkg::DATA_W-1:0] rdata_o,
  input wire logic conv_done_i,
  input wire logic [acq_regs_pkg::RESULT_W-1:0] conv_data_i,
  input wire logic [DIGIN_W-1:0] digital_inputs_i,
  input wire logic [acq_regs_pkg::DATA_W-1:0] counter_rdata_i,
  output logic [acq_regs_pkg::CHAN_W-1:0] mux_channel_o,
  output logic [acq_regs_pkg::GAIN_W-1:0] amp_gain_o,
  output logic conv_start_o,
  output logic counter_rd_o,
  output logic counter_wr_o,
  output logic [1:0] counter_port_o,
  output logic [acq_regs_pkg::DATA_W-1:0] wdata_o,
  output logic dac_low_wr_o,
  output logic dac_high_wr_o,
  output logic irq_clear_o,
  output logic mode_wr_o,
  output logic digout_low_wr_o,
  output logic digout_high_wr_o
);
  import acq_regs_pkg::*;

  logic [CHAN_W-1:0] chan_q, chan_d;
  logic [GAIN_W-1:0] gain_q, gain_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic start_q, start_d;
  logic crd_q, crd_d;
  logic cwr_q, cwr_d;
  logic [1:0] cport_q, cport_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic dlo_q, dlo_d, dhi_q, dhi_d;
  logic irqc_q, irqc_d, mode_q, mode_d;
  logic dolo_q, dolo_d, dohi_q, dohi_d;
  logic consume;
  logic [RESULT_W-1:0] result;
  logic pending_n;

  // Digital inputs are read back as exactly two bytes
  if (DIGIN_W != 2 * DATA_W) begin : g_digin_check
    $error("digital input width must be 16");
  end

  // Strobe qualified by one offset; all inputs passed in so callers track them
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] off);
    return strobe && (addr == off);
  endfunction

  assign consume = hit(rd_i, addr_i, OFF_RESULT_LOW);

  result_holder #(
    .WIDTH(RESULT_W)
  ) u_result (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .done_i(conv_done_i),
    .data_i(conv_data_i),
    .consume_i(consume),
    .result_o(result),
    .pending_n_o(pending_n)
  );

  // Read data mux, registered
  always_comb begin
    rdata_d = rdata_q;
    crd_d = 1'b0;
    if (rd_i) begin
      case (addr_i)
        OFF_COUNTER0, OFF_COUNTER1, OFF_COUNTER2: begin
          rdata_d = counter_rdata_i;
          crd_d = 1'b1;
        end
        OFF_RESULT_LOW: rdata_d = result[DATA_W-1:0];
        OFF_RESULT_HIGH: begin
          rdata_d = {3'h0, pending_n, result[RESULT_W-1:DATA_W]};
        end
        OFF_DIGIN_LOW: rdata_d = digital_inputs_i[DATA_W-1:0];
        OFF_DIGIN_HIGH: rdata_d = digital_inputs_i[DIGIN_W-1:DATA_W];
        default: rdata_d = UNUSED_READ;
      endcase
    end
  end

  // Write decode and control registers
  always_comb begin
    chan_d = chan_q;
    gain_d = gain_q;
    wdata_d = wdata_q;
    cwr_d = 1'b0;
    cport_d = cport_q;
    dlo_d = hit(wr_i, addr_i, OFF_RESULT_LOW);
    dhi_d = hit(wr_i, addr_i, OFF_RESULT_HIGH);
    irqc_d = hit(wr_i, addr_i, OFF_IRQ_CLEAR);
    mode_d = hit(wr_i, addr_i, OFF_MODE);
    start_d = hit(wr_i, addr_i, OFF_SOFT_TRIGGER);
    dolo_d = hit(wr_i, addr_i, OFF_DIGOUT_LOW);
    dohi_d = hit(wr_i, addr_i, OFF_DIGOUT_HIGH);
    if (wr_i) begin
      wdata_d = wdata_i;
    end
    if (wr_i && addr_i <= OFF_COUNTER_CTRL) begin
      cwr_d = 1'b1;
    end
    // Offset 3 reads are unused and must leave the port alone
    if ((wr_i && addr_i <= OFF_COUNTER_CTRL) || (rd_i && addr_i < OFF_COUNTER_CTRL)) begin
      cport_d = addr_i[1:0];
    end
    if (hit(wr_i, addr_i, OFF_CHANNEL_SELECT)) begin
      chan_d = wdata_i[CHAN_W-1:0];
    end
    if (hit(wr_i, addr_i, OFF_GAIN_SELECT)) begin
      gain_d = wdata_i[GAIN_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chan_q <= CHAN_RESET;
      gain_q <= GAIN_RESET;
      rdata_q <= UNUSED_READ;
      start_q <= 1'b0;
      crd_q <= 1'b0;
      cwr_q <= 1'b0;
      cport_q <= 2'h0;
      wdata_q <= 8'h00;
      dlo_q <= 1'b0;
      dhi_q <= 1'b0;
      irqc_q <= 1'b0;
      mode_q <= 1'b0;
      dolo_q <= 1'b0;
      dohi_q <= 1'b0;
    end else begin
      chan_q <= chan_d;
      gain_q <= gain_d;
      rdata_q <= rdata_d;
      start_q <= start_d;
      crd_q <= crd_d;
      cwr_q <= cwr_d;
      cport_q <= cport_d;
      wdata_q <= wdata_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      irqc_q <= irqc_d;
      mode_q <= mode_d;
      dolo_q <= dolo_d;
      dohi_q <= dohi_d;
    end
  end

  assign mux_channel_o = chan_q;
  assign amp_gain_o = gain_q;
  assign conv_start_o = start_q;
  assign rdata_o = rdata_q;
  assign counter_rd_o = crd_q;
  assign counter_wr_o = cwr_q;
  assign counter_port_o = cport_q;
  assign wdata_o = wdata_q;
  assign dac_low_wr_o = dlo_q;
  assign dac_high_wr_o = dhi_q;
  assign irq_clear_o = irqc_q;
  assign mode_wr_o = mode_q;
  assign digout_low_wr_o = dolo_q;
  assign digout_high_wr_o = dohi_q;

  sequence s_chan_write;
    wr_i && addr_i == OFF_CHANNEL_SELECT;
  endsequence
  sequence s_gain_write;
    wr_i && addr_i == OFF_GAIN_SELECT;
  endsequence
  sequence s_trig_write;
    wr_i && addr_i == OFF_SOFT_TRIGGER;
  endsequence

  property p_chan_follows;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_chan_write |=> mux_channel_o == $past(wdata_i[2:0]);
  endproperty
  a_chan_follows: assert property (p_chan_follows)
    else $error("Channel not switched after write");

  property p_gain_follows;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_gain_write |=> amp_gain_o == $past(wdata_i[2:0]);
  endproperty
  a_gain_follows: assert property (p_gain_follows)
    else $error("Gain not updated after write");

  property p_chan_holds;
    @(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == OFF_CHANNEL_SELECT) |=> $stable(mux_channel_o);
  endproperty
  a_chan_holds: assert property (p_chan_holds)
    else $error("Channel changed without its write");

  property p_gain_holds;
    @(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == OFF_GAIN_SELECT) |=> $stable(amp_gain_o);
  endproperty
  a_gain_holds: assert property (p_gain_holds)
    else $error("Gain changed without its write");

  property p_trigger;
    @(posedge clk_i) disable iff (!reset_n_i)
      s_trig_write |=> conv_start_o;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("No conversion start after trigger write");

  property p_no_spurious_start;
    @(posedge clk_i) disable iff (!reset_n_i)
      !(wr_i && addr_i == OFF_SOFT_TRIGGER) |=> !conv_start_o;
  endproperty
  a_no_spurious_start: assert property (p_no_spurious_start)
    else $error("Conversion start without trigger write");

  property p_high_byte;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == OFF_RESULT_HIGH) |=>
        rdata_o == {3'h0, $past(pending_n), $past(result[11:8])};
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("High result byte layout wrong");

  property p_low_byte;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && addr_i == OFF_RESULT_LOW) |=> rdata_o == $past(result[7:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("Low result byte wrong");

  property p_unused_read;
    @(posedge clk_i) disable iff (!reset_n_i)
      (rd_i && (addr_i > OFF_DIGIN_HIGH || addr_i == OFF_COUNTER_CTRL)) |=> rdata_o == 8'h00;
  endproperty
  a_unused_read: assert property (p_unused_read)
    else $error("Unused offset did not read zero");
endmodule

// File: src/result_holder.sv
// Holds the conversion result and its active-low ready flag
`timescale 1ns/100ps
module result_holder #(
  parameter int WIDTH = acq_regs_pkg::RESULT_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic done_i,
  input wire logic [WIDTH-1:0] data_i,
  input wire logic consume_i,
  output logic [WIDTH-1:0] result_o,
  output logic pending_n_o
);
  import acq_regs_pkg::*;

  logic [WIDTH-1:0] result_q, result_d;
  logic pending_n_q, pending_n_d;

  // Refuse widths the byte split cannot serve
  if (WIDTH != RESULT_W) begin : g_width_check
    $error("result width must be 12");
  end

  always_comb begin
    result_d = result_q;
    pending_n_d = pending_n_q;
    if (consume_i) begin
      pending_n_d = 1'b1;
    end
    if (done_i) begin
      result_d = data_i;
      pending_n_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_q <= '0;
      pending_n_q <= 1'b1;
    end else begin
      result_q <= result_d;
      pending_n_q <= pending_n_d;
    end
  end

  assign result_o = result_q;
  assign pending_n_o = pending_n_q;

  property p_done_sets_ready;
    @(posedge clk_i) disable iff (!reset_n_i)
      done_i |=> (!pending_n_q && result_q == $past(data_i));
  endproperty
  a_done_sets_ready: assert property (p_done_sets_ready)
    else $error("Ready flag not set after completion");

  property p_consume_clears;
    @(posedge clk_i) disable iff (!reset_n_i)
      (consume_i && !done_i) |=> pending_n_q;
  endproperty
  a_consume_clears: assert property (p_consume_clears)
    else $error("Ready flag not cleared by low byte read");
endmodule

// File: testbench/adc_card_register_interface_test.sv
// Self-checking bench for the card register front end
`timescale 1ns/100ps
module adc_card_register_interface_test;
  import acq_regs_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, rd_i = 1'b0, wr_i = 1'b0, slow = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, cnt_i = 8'h00, rdata_o, b, wd = 8'h00, wd_o;
  wire logic [7:0] sv;
  logic [1:0] cp = 2'h0, cp_o;
  logic [11:0] val = 12'h000, cd;
  logic [15:0] di = 16'h0000;
  logic [2:0] ch = 3'h0, gn = 3'h0, mux, amp;
  logic done, crd, rd_seen = 1'b0, wr_seen = 1'b0;
  logic [31:0] x = 32'h17cd8;
  logic [8:0] rq[$];
  logic [23:0] wq[$];
  int mismatches = 0, compares = 0;

  always #12.5 clk_i = ~clk_i;

  adc_card_register_interface dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .rd_i(rd_i), .wr_i(wr_i), .rdata_o(rdata_o), .conv_done_i(done),
    .conv_data_i(cd), .digital_inputs_i(di), .counter_rdata_i(cnt_i), .mux_channel_o(mux),
    .amp_gain_o(amp), .conv_start_o(sv[2]), .counter_rd_o(crd), .counter_wr_o(sv[7]),
    .counter_port_o(cp_o), .wdata_o(wd_o), .dac_low_wr_o(sv[6]), .dac_high_wr_o(sv[5]),
    .irq_clear_o(sv[4]), .mode_wr_o(sv[3]), .digout_low_wr_o(sv[1]), .digout_high_wr_o(sv[0]));
  adc_model model (.clk_i(clk_i), .reset_n_i(reset_n_i), .start_i(sv[2]), .slow_i(slow),
    .value_i(val), .done_o(done), .data_o(cd));

  function automatic logic [7:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x[7:0];
  endfunction

  // Expected strobe pattern per write offset, bit order as wired to sv
  function automatic logic [7:0] strobe_exp(input logic [3:0] a);
    case (a)
      4'h0, 4'h1, 4'h2, 4'h3: return 8'h80;
      4'h4: return 8'h40;
      4'h5: return 8'h20;
      4'h8: return 8'h10;
      4'hb: return 8'h08;
      4'hc: return 8'h04;
      4'hd: return 8'h02;
      4'he: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chk_rd(input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_wr(input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic acc(input logic r, input logic w, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    rd_i = r;
    wr_i = w;
    addr_i = a;
    wdata_i = d;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    acc(1'b0, 1'b1, a, d);
    if (a == 4'ha) ch = d[2:0];
    if (a == 4'h9) gn = d[2:0];
    if (a <= 4'h3) cp = a[1:0];
    wd = d;
    wq.push_back({strobe_exp(a), ch, gn, wd, cp});
  endtask

  task automatic rd(input logic [3:0] a, input logic [8:0] e);
    acc(1'b1, 1'b0, a, rnd());
    cnt_i = rnd();
    di = {rnd(), rnd()};
    if (a < 4'h3) begin
      e = {1'b1, cnt_i};
      cp = a[1:0];
    end
    else if (a == 4'h6) e = {1'b0, di[7:0]};
    else if (a == 4'h7) e = {1'b0, di[15:8]};
    else if (a != 4'h4 && a != 4'h5) e = 9'h000;
    rq.push_back(e);
  endtask

  task automatic wait_done();
    for (int k = 0; k < 40; k++) begin
      acc(1'b0, 1'b0, 4'h0, 8'h00);
      if (done === 1'b1) return;
    end
    mismatches++;
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i) begin
    rd_seen <= rd_i;
    wr_seen <= wr_i;
  end

  always @(negedge clk_i) begin
    if (rd_seen) chk_rd(rq.pop_front(), {crd, rdata_o});
    if (wr_seen) chk_wr(wq.pop_front(), {sv, mux, amp, wd_o, cp_o});
  end

  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    chk_wr(24'h000000, {sv, mux, amp, wd_o, cp_o});
    rd(4'h5, 9'h010);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      b = rnd();
      wr(4'ha, {b[7:3], i[2:0]});
      wr(4'h9, {b[7:3], 3'(i % 5)});
    end
    $display("test channel and gain done");
    b = rnd();
    val = {b[3:0], rnd()};
    for (int a = 0; a < 16; a++) begin
      b = rnd();
      if (a == 9) b[2:0] = 3'h4;
      wr(4'(a), b);
    end
    wait_done();
    rd(4'h4, {1'b0, val[7:0]});
    for (int a = 0; a < 16; a++)
      if (a != 4 && a != 5) rd(4'(a), 9'h000);
    rd(4'h5, {5'h01, val[11:8]});
    $display("test maps done");
    for (int n = 0; n < 2; n++) begin
      slow = n[0];
      b = rnd();
      val = {b[3:0], rnd()};
      wr(4'hc, rnd());
      wait_done();
      rd(4'h5, {5'h00, val[11:8]});
      rd(4'h4, {1'b0, val[7:0]});
      rd(4'h5, {5'h01, val[11:8]});
    end
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    $display("test conversions done");
    wr(4'ha, 8'h07);
    wr(4'h9, 8'h03);
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    reset_n_i = 1'b0;
    {ch, gn, wd, cp} = '0;
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    reset_n_i = 1'b1;
    chk_wr(24'h000000, {sv, mux, amp, wd_o, cp_o});
    rd(4'h5, 9'h010);
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    acc(1'b0, 1'b0, 4'h0, 8'h00);
    $display("test second reset done");
    summarize();
  end

  // The whole run takes little over a hundred cycles; this span means a hang
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    summarize();
  end
endmodule

// File: testbench/adc_model.sv
// Converter model: answers a start pulse after a short or a long delay
`timescale 1ns/100ps
module adc_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic slow_i,
  input wire logic [11:0] value_i,
  output logic done_o,
  output logic [11:0] data_o
);
  int cnt;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
      done_o <= 1'b0;
      data_o <= 12'h000;
    end else begin
      done_o <= 1'b0;
      // Data is only valid with done, so it toggles otherwise
      data_o <= ~data_o;
      if (start_i) begin
        cnt <= slow_i ? 20 : 3;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      if (!start_i && cnt == 1) begin
        done_o <= 1'b1;
        data_o <= value_i;
      end
    end
  end
endmodule
